// *** ictr_pkg.sv ***
// Notes on behaviour
// - Bus-master base bits 31:4 writable, 16-byte IO window, low nibble reads 0001.
// - Subsystem identifiers read-only here, reset zero, written only through alias port.
// - Interrupt line writable if either channel native, else reads 00h.
// - Interrupt pin reads 01h if either channel native, else 00h.
// - Minimum-grant and maximum-latency bytes read-only zero.
// - Config bit 0 enables secondary channel, bit 1 primary; both read-write.
// - Bits 12/14 enable posted-write buffers; then only 32-bit data-port writes allowed.
// - Bit 13 enables secondary prefetch buffer, bit 15 primary prefetch buffer.
// - Config bits 23:20 are plain scratch storage.
// - Each 4-bit timing field lasts value plus one clocks.
// - Drive pulse/recovery fields time data-port PIO and DMA only.
// - Drive timing bytes from top: pri0, pri1, sec0, sec1; pulse high, recovery low.
// - Setup fields at 7:6,5:4,3:2,1:0 give value plus one clocks for all cycles.
// - Bits 31:16 hold task-file pulse/recovery; primary upper byte, secondary lower.
// - Ultra DMA bytes: 31:24 pri master, 23:16 pri slave, 15:8 sec master, 7:0 sec slave.
// - Cycle codes 0..6 select 60,90,120,150,45,30,20 ns.
// - Ultra DMA byte bits 5:3 read-only zero.
// - Ultra DMA byte bit 6 is read-write transfer enable.
// - Bit 7 set uses bit 6; clear enables on Set Features to that drive.
// - Native-mode bits decide addressing; low means compatibility mode.
`default_nettype none
package ictr_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BM_BASE  = 8'h20;
  localparam logic [7:0] OFS_SUBSYS   = 8'h2c;
  localparam logic [7:0] OFS_INTINFO  = 8'h3c;
  localparam logic [7:0] OFS_CHANCFG  = 8'h40;
  localparam logic [7:0] OFS_DRVTIME  = 8'h48;
  localparam logic [7:0] OFS_CYCSETUP = 8'h4c;
  localparam logic [7:0] OFS_UDMA     = 8'h50;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_BM_BASE   = 32'h0000cc01;
  localparam logic [31:0] BM_FIXED_LOW  = 32'h00000001;
  localparam logic [31:0] MSK_BM_BASE   = 32'hfffffff0;
  localparam logic [31:0] RST_ZERO      = 32'h00000000;
  localparam logic [31:0] RST_CHANCFG   = 32'h00000400;
  localparam logic [31:0] MSK_CHANCFG   = 32'h00ffff1f;
  localparam logic [31:0] RST_DRVTIME   = 32'ha8a8a8a8;
  localparam logic [31:0] MSK_DRVTIME   = 32'hffffffff;
  localparam logic [31:0] RST_CYCSETUP  = 32'hffff00ff;
  localparam logic [31:0] MSK_CYCSETUP  = 32'hffff00ff;
  localparam logic [31:0] RST_UDMA      = 32'h03030303;
  localparam logic [31:0] MSK_UDMA      = 32'hc7c7c7c7;
  localparam logic [31:0] MSK_INTLINE   = 32'h000000ff;
  localparam logic [7:0]  INT_PIN_NATIVE = 8'h01;
  localparam logic [7:0]  INT_PIN_COMPAT = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_SEC_ON     = 0;
  localparam int CFG_PRI_ON     = 1;
  localparam int CFG_SEC_PWB    = 12;
  localparam int CFG_SEC_RPB    = 13;
  localparam int CFG_PRI_PWB    = 14;
  localparam int CFG_PRI_RPB    = 15;
  localparam int CFG_CABLE_LO   = 16;
  localparam int CFG_SCRATCH_LO = 20;
  localparam int UDMA_EN_BIT    = 6;
  localparam int UDMA_METHOD    = 7;
  localparam int TASK_PRI_LO    = 24;
  localparam int TASK_SEC_LO    = 16;
  localparam int BYTE_W         = 8;

  // Drive index: 0 pri drive0, 1 pri drive1, 2 sec drive0, 3 sec drive1
  localparam int NUM_DRIVES = 4;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_PULSE = 2'b10,
    ST_RECOV = 2'b11
  } ictr_strobe_state_t;

  // Cycle time in ns for each ultra cycle code
  function automatic logic [7:0] ultraCycleNs(input logic [2:0] code);
    case (code)
      3'h0:    ultraCycleNs = 8'd60;
      3'h1:    ultraCycleNs = 8'd90;
      3'h2:    ultraCycleNs = 8'd120;
      3'h3:    ultraCycleNs = 8'd150;
      3'h4:    ultraCycleNs = 8'd45;
      3'h5:    ultraCycleNs = 8'd30;
      3'h6:    ultraCycleNs = 8'd20;
      default: ultraCycleNs = 8'd0;
    endcase
  endfunction : ultraCycleNs
endpackage : ictr_pkg
`default_nettype wire

// *** ictr_strobe_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module ictr_strobe_timer (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       isWrite,
  input  wire logic [1:0] setupField,
  input  wire logic [3:0] pulseField,
  input  wire logic [3:0] recoveryField,
  output logic            busy,
  output logic            done,
  output logic            drive_read_strobe_n,
  output logic            drive_write_strobe_n
);
  ictr_pkg::ictr_strobe_state_t stateQ, stateD;
  logic [3:0] countQ, countD;
  logic [3:0] pulseQ, pulseD;
  logic [3:0] recovQ, recovD;
  logic       writeQ, writeD;
  logic       doneD;
  logic       readND, writeND;

  // ---------------------------------------------------------------
  // Setup, pulse, recovery sequencer
  // ---------------------------------------------------------------
  always_comb begin
    stateD  = stateQ;
    countD  = countQ;
    pulseD  = pulseQ;
    recovD  = recovQ;
    writeD  = writeQ;
    doneD   = 1'b0;
    case (stateQ)
      ictr_pkg::ST_IDLE: begin
        if (start) begin
          // Fields captured here so a mid-access write waits for next access
          pulseD = pulseField;
          recovD = recoveryField;
          writeD = isWrite;
          countD = {2'b00, setupField};
          stateD = ictr_pkg::ST_SETUP;
        end
      end
      ictr_pkg::ST_SETUP: begin
        if (countQ == 4'h0) begin
          countD = pulseQ;
          stateD = ictr_pkg::ST_PULSE;
        end else begin
          countD = countQ - 4'h1;
        end
      end
      ictr_pkg::ST_PULSE: begin
        if (countQ == 4'h0) begin
          countD = recovQ;
          stateD = ictr_pkg::ST_RECOV;
        end else begin
          countD = countQ - 4'h1;
        end
      end
      ictr_pkg::ST_RECOV: begin
        if (countQ == 4'h0) begin
          doneD  = 1'b1;
          stateD = ictr_pkg::ST_IDLE;
        end else begin
          countD = countQ - 4'h1;
        end
      end
      default: stateD = ictr_pkg::ST_IDLE;
    endcase
    readND  = !(stateD == ictr_pkg::ST_PULSE && !writeD);
    writeND = !(stateD == ictr_pkg::ST_PULSE && writeD);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stateQ               <= ictr_pkg::ST_IDLE;
      countQ               <= 4'h0;
      pulseQ               <= 4'h0;
      recovQ               <= 4'h0;
      writeQ               <= 1'b0;
      done                 <= 1'b0;
      drive_read_strobe_n  <= 1'b1;
      drive_write_strobe_n <= 1'b1;
    end else begin
      stateQ               <= stateD;
      countQ               <= countD;
      pulseQ               <= pulseD;
      recovQ               <= recovD;
      writeQ               <= writeD;
      done                 <= doneD;
      drive_read_strobe_n  <= readND;
      drive_write_strobe_n <= writeND;
    end
  end

  assign busy = (stateQ != ictr_pkg::ST_IDLE);
endmodule : ictr_strobe_timer
`default_nettype wire

// *** ictr_udma_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
module ictr_udma_ctl (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] controlByte,
  input  wire logic       setFeaturesSeen,
  output logic            ultraEnabled,
  output logic [7:0]      ultraCycleNs
);
  logic autoQ, autoD;
  logic enD;
  logic [7:0] nsD;

  // ---------------------------------------------------------------
  // Enable method and cycle time
  // ---------------------------------------------------------------
  always_comb begin
    // Auto flag is sticky until reset; a new command only re-confirms it
    autoD = autoQ | setFeaturesSeen;
    enD   = controlByte[ictr_pkg::UDMA_METHOD] ?
            controlByte[ictr_pkg::UDMA_EN_BIT] : autoQ;
    nsD   = ictr_pkg::ultraCycleNs(controlByte[2:0]);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      autoQ        <= 1'b0;
      ultraEnabled <= 1'b0;
      ultraCycleNs <= 8'h00;
    end else begin
      autoQ        <= autoD;
      ultraEnabled <= enD;
      ultraCycleNs <= nsD;
    end
  end
endmodule : ictr_udma_ctl
`default_nettype wire

// *** ictr_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module ictr_config_regs (
  input  wire logic        clk,
  input  wire logic        reset,
  // Configuration access, function 1
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWriteData,
  output logic [31:0]      cfgReadData,
  output logic             cfgReadValid,
  // Subsystem identifier alias path
  input  wire logic        subsysAliasWrite,
  input  wire logic [31:0] subsysAliasData,
  // Native-mode bits from the programming-interface register
  input  wire logic        priNative,
  input  wire logic        secNative,
  // Drive access requests, one per channel (0 primary, 1 secondary)
  input  wire logic [1:0]  accessStart,
  input  wire logic [1:0]  accessWrite,
  input  wire logic [1:0]  accessDrive,
  input  wire logic [1:0]  accessDataPort,
  input  wire logic [1:0]  accessWord32,
  output logic [1:0]       accessBusy,
  output logic [1:0]       accessDone,
  output logic [1:0]       accessRefused,
  output logic [1:0]       drive_read_strobe_n,
  output logic [1:0]       drive_write_strobe_n,
  // Per drive: 0 pri master, 1 pri slave, 2 sec master, 3 sec slave
  input  wire logic [3:0]  setFeaturesSeen,
  output logic [3:0]       ultraEnabled,
  output logic [31:0]      ultraCycleNs,
  output logic [3:0]       cable80,
  output logic [1:0]       channelOn,
  output logic [1:0]       postedWriteOn,
  output logic [1:0]       prefetchOn,
  output logic [27:0]      busMasterIoBase
);
  logic [31:0] bmBaseQ, bmBaseD;
  logic [31:0] subsysQ, subsysD;
  logic [7:0]  intLineQ, intLineD;
  logic [31:0] chanCfgQ, chanCfgD;
  logic [31:0] drvTimeQ, drvTimeD;
  logic [31:0] cycSetupQ, cycSetupD;
  logic [31:0] udmaQ, udmaD;
  logic [31:0] readD;
  logic [31:0] intMerged;
  logic        anyNative;

  // ---------------------------------------------------------------
  // Byte-lane merge
  // ---------------------------------------------------------------
  // Bits outside the mask keep their stored value, so reserved bits stay zero
  function automatic logic [31:0] mergeWord(input logic [31:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be,
                                            input logic [31:0] mask);
    logic [31:0] laneMask;
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    mergeWord = (old & ~laneMask) | (wdata & laneMask);
  endfunction : mergeWord

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction : hit

  assign anyNative = priNative | secNative;
  assign intMerged = mergeWord({24'h000000, intLineQ}, cfgWriteData, cfgByteEn,
                               ictr_pkg::MSK_INTLINE);

  // ---------------------------------------------------------------
  // Register write path
  // ---------------------------------------------------------------
  always_comb begin
    bmBaseD   = bmBaseQ;
    subsysD   = subsysQ;
    intLineD  = intLineQ;
    chanCfgD  = chanCfgQ;
    drvTimeD  = drvTimeQ;
    cycSetupD = cycSetupQ;
    udmaD     = udmaQ;
    if (cfgWrite) begin
      if (hit(cfgAddr, ictr_pkg::OFS_BM_BASE)) begin
        bmBaseD = mergeWord(bmBaseQ, cfgWriteData, cfgByteEn,
                            ictr_pkg::MSK_BM_BASE);
      end
      if (hit(cfgAddr, ictr_pkg::OFS_INTINFO) && anyNative) begin
        intLineD = intMerged[7:0];
      end
      if (hit(cfgAddr, ictr_pkg::OFS_CHANCFG)) begin
        // Bits the software must not alter stay writable by design
        chanCfgD = mergeWord(chanCfgQ, cfgWriteData, cfgByteEn,
                             ictr_pkg::MSK_CHANCFG);
      end
      if (hit(cfgAddr, ictr_pkg::OFS_DRVTIME)) begin
        drvTimeD = mergeWord(drvTimeQ, cfgWriteData, cfgByteEn,
                             ictr_pkg::MSK_DRVTIME);
      end
      if (hit(cfgAddr, ictr_pkg::OFS_CYCSETUP)) begin
        cycSetupD = mergeWord(cycSetupQ, cfgWriteData, cfgByteEn,
                              ictr_pkg::MSK_CYCSETUP);
      end
      if (hit(cfgAddr, ictr_pkg::OFS_UDMA)) begin
        udmaD = mergeWord(udmaQ, cfgWriteData, cfgByteEn,
                          ictr_pkg::MSK_UDMA);
      end
    end
    // Alias port is the only writer of the identifiers
    if (subsysAliasWrite) begin
      subsysD = subsysAliasData;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    readD = ictr_pkg::RST_ZERO;
    if (hit(cfgAddr, ictr_pkg::OFS_BM_BASE)) begin
      readD = (bmBaseQ & ictr_pkg::MSK_BM_BASE) | ictr_pkg::BM_FIXED_LOW;
    end else if (hit(cfgAddr, ictr_pkg::OFS_SUBSYS)) begin
      readD = subsysQ;
    end else if (hit(cfgAddr, ictr_pkg::OFS_INTINFO)) begin
      // Grant and latency bytes are constant zero
      readD = {16'h0000,
               anyNative ? ictr_pkg::INT_PIN_NATIVE : ictr_pkg::INT_PIN_COMPAT,
               anyNative ? intLineQ : 8'h00};
    end else if (hit(cfgAddr, ictr_pkg::OFS_CHANCFG)) begin
      readD = chanCfgQ & ictr_pkg::MSK_CHANCFG;
    end else if (hit(cfgAddr, ictr_pkg::OFS_DRVTIME)) begin
      readD = drvTimeQ;
    end else if (hit(cfgAddr, ictr_pkg::OFS_CYCSETUP)) begin
      readD = cycSetupQ & ictr_pkg::MSK_CYCSETUP;
    end else if (hit(cfgAddr, ictr_pkg::OFS_UDMA)) begin
      readD = udmaQ & ictr_pkg::MSK_UDMA;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bmBaseQ      <= ictr_pkg::RST_BM_BASE;
      subsysQ      <= ictr_pkg::RST_ZERO;
      intLineQ     <= 8'h00;
      chanCfgQ     <= ictr_pkg::RST_CHANCFG;
      drvTimeQ     <= ictr_pkg::RST_DRVTIME;
      cycSetupQ    <= ictr_pkg::RST_CYCSETUP;
      udmaQ        <= ictr_pkg::RST_UDMA;
      cfgReadData  <= ictr_pkg::RST_ZERO;
      cfgReadValid <= 1'b0;
    end else begin
      bmBaseQ      <= bmBaseD;
      subsysQ      <= subsysD;
      intLineQ     <= intLineD;
      chanCfgQ     <= chanCfgD;
      drvTimeQ     <= drvTimeD;
      cycSetupQ    <= cycSetupD;
      udmaQ        <= udmaD;
      cfgReadData  <= cfgRead ? readD : cfgReadData;
      cfgReadValid <= cfgRead;
    end
  end

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  assign busMasterIoBase = bmBaseQ[31:4];
  assign channelOn       = {chanCfgQ[ictr_pkg::CFG_SEC_ON], chanCfgQ[ictr_pkg::CFG_PRI_ON]};
  assign postedWriteOn   = {chanCfgQ[ictr_pkg::CFG_SEC_PWB],
                            chanCfgQ[ictr_pkg::CFG_PRI_PWB]};
  assign prefetchOn      = {chanCfgQ[ictr_pkg::CFG_SEC_RPB],
                            chanCfgQ[ictr_pkg::CFG_PRI_RPB]};
  assign cable80         = chanCfgQ[ictr_pkg::CFG_CABLE_LO +: 4];

  // ---------------------------------------------------------------
  // Per-channel strobe timing
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      logic [1:0] drvIdx;
      logic [7:0] drvByte;
      logic [7:0] taskByte;
      logic [1:0] setupSel;
      logic [3:0] pulseSel;
      logic [3:0] recovSel;
      logic       startOk;
      // Drive byte 3 is the top byte (primary drive 0)
      assign drvIdx   = 2'(2 * ch) + {1'b0, accessDrive[ch]};
      assign drvByte  = drvTimeQ[(3 - drvIdx) * ictr_pkg::BYTE_W +: 8];
      assign taskByte = cycSetupQ[(ch == 0 ? ictr_pkg::TASK_PRI_LO : ictr_pkg::TASK_SEC_LO)
                                  +: 8];
      assign setupSel = cycSetupQ[(3 - drvIdx) * 2 +: 2];
      // Task-file ports use their own pair; only the data port uses the drive byte
      assign pulseSel = accessDataPort[ch] ? drvByte[7:4] : taskByte[7:4];
      assign recovSel = accessDataPort[ch] ? drvByte[3:0] : taskByte[3:0];
      // Narrow data-port writes are refused while the posted-write buffer is on
      assign accessRefused[ch] = accessStart[ch] & accessWrite[ch] & accessDataPort[ch]
                                 & postedWriteOn[ch] & ~accessWord32[ch];
      assign startOk = accessStart[ch] & channelOn[ch] & ~accessRefused[ch];

      ictr_strobe_timer uTimer (
        .clk                  (clk),
        .reset                (reset),
        .start                (startOk),
        .isWrite              (accessWrite[ch]),
        .setupField           (setupSel),
        .pulseField           (pulseSel),
        .recoveryField        (recovSel),
        .busy                 (accessBusy[ch]),
        .done                 (accessDone[ch]),
        .drive_read_strobe_n  (drive_read_strobe_n[ch]),
        .drive_write_strobe_n (drive_write_strobe_n[ch])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Per-drive ultra DMA control
  // ---------------------------------------------------------------
  genvar dr;
  generate
    for (dr = 0; dr < ictr_pkg::NUM_DRIVES; dr++) begin : gDrive
      ictr_udma_ctl uUltra (
        .clk             (clk),
        .reset           (reset),
        .controlByte     (udmaQ[(3 - dr) * ictr_pkg::BYTE_W +: 8]),
        .setFeaturesSeen (setFeaturesSeen[dr]),
        .ultraEnabled    (ultraEnabled[dr]),
        .ultraCycleNs    (ultraCycleNs[dr * 8 +: 8])
      );
    end
  endgenerate
endmodule : ictr_config_regs
`default_nettype wire

// *** ictr_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Drive side: measures how long each channel's strobes stay low
// ----
module ictr_drive_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] readStrobe_n,
  input  wire logic [1:0] writeStrobe_n,
  output logic      [4:0] lowLen0,
  output logic      [4:0] lowLen1
);
  logic [4:0] cnt_q [2];
  logic [4:0] cnt_d [2];
  logic [4:0] len_q [2];
  logic [4:0] len_d [2];
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cnt_d[c] = cnt_q[c];
      len_d[c] = len_q[c];
      if (!(readStrobe_n[c] & writeStrobe_n[c])) begin
        cnt_d[c] = cnt_q[c] + 5'h1;
      end else if (cnt_q[c] != 5'h0) begin
        len_d[c] = cnt_q[c];
        cnt_d[c] = 5'h0;
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '{5'h0, 5'h0};
      len_q <= '{5'h0, 5'h0};
    end else begin
      cnt_q <= cnt_d;
      len_q <= len_d;
    end
  end
  assign lowLen0 = len_q[0];
  assign lowLen1 = len_q[1];
endmodule : ictr_drive_model
`default_nettype wire

// *** ictr_config_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ictr_config_regs_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cfgRead,
  input wire logic [7:0]  cfgAddr,
  input wire logic [31:0] cfgReadData,
  input wire logic        priNative,
  input wire logic        secNative,
  input wire logic [1:0]  accessStart,
  input wire logic [1:0]  accessWrite,
  input wire logic [1:0]  accessDataPort,
  input wire logic [1:0]  accessWord32,
  input wire logic [1:0]  accessBusy,
  input wire logic [1:0]  accessDone,
  input wire logic [1:0]  accessRefused,
  input wire logic [1:0]  drive_read_strobe_n,
  input wire logic [1:0]  channelOn,
  input wire logic [1:0]  postedWriteOn,
  input wire logic [3:0]  ultraEnabled
);
  logic mapped;
  logic nat;
  assign mapped = cfgAddr[7:2] inside {6'h08, 6'h0b, 6'h0f, 6'h10, 6'h12, 6'h13, 6'h14};
  assign nat = priNative | secNative;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  unmapped_zero_a: assert property (cfgRead && !mapped |=> cfgReadData == 32'h0)
    else $error("unmapped read not zero");
  bm_nibble_a: assert property (cfgRead && cfgAddr[7:2] == 6'h08 |=> cfgReadData[3:0] == 4'h1)
    else $error("base low nibble wrong");
  int_pin_a: assert property (cfgRead && cfgAddr[7:2] == 6'h0f |=>
    cfgReadData[15:8] == ($past(nat) ? 8'h01 : 8'h00))
    else $error("interrupt pin wrong");
  grant_lat_a: assert property (cfgRead && cfgAddr[7:2] == 6'h0f |=> cfgReadData[31:16] == 16'h0)
    else $error("grant or latency not zero");
  cfg_rsvd_a: assert property (cfgRead && cfgAddr[7:2] == 6'h10 |=>
    (cfgReadData & 32'hff0000e0) == 32'h0)
    else $error("config reserved bits set");
  udma_fixed_a: assert property (cfgRead && cfgAddr[7:2] == 6'h14 |=>
    (cfgReadData & 32'h38383838) == 32'h0)
    else $error("ultra fixed bits set");
  narrow_refuse_a: assert property (accessRefused[0] |-> accessStart[0] && accessWrite[0] &&
    accessDataPort[0] && !accessWord32[0] && postedWriteOn[0])
    else $error("refusal without cause");
  chan_off_a: assert property (accessStart[0] && !channelOn[0] |=> !accessBusy[0])
    else $error("disabled channel started");
  setup_first_a: assert property (accessStart[0] && channelOn[0] && !accessBusy[0] &&
    !accessRefused[0] |=> drive_read_strobe_n[0])
    else $error("strobe without setup phase");
  recov_done_a: assert property ($rose(drive_read_strobe_n[0]) |-> ##[1:16] accessDone[0])
    else $error("recovery too long");
  cover property (accessRefused[0]);
  cover property ($fell(drive_read_strobe_n[1]));
  cover property ($rose(ultraEnabled[3]));
endmodule : ictr_config_regs_monitor
bind ictr_config_regs ictr_config_regs_monitor u_ictr_config_regs_monitor (.*);
`default_nettype wire

// *** tb_ictr_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ictr_config_regs;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfgWrite = 1'b0, cfgRead = 1'b0, subsysAliasWrite = 1'b0;
  logic priNative = 1'b0, secNative = 1'b0;
  logic [7:0] cfgAddr = 8'h0;
  logic [3:0] cfgByteEn = 4'h0, setFeaturesSeen = 4'h0;
  logic [31:0] cfgWriteData = 32'h0, subsysAliasData = 32'h0;
  logic [1:0] accessStart = 2'h0, accessWrite = 2'h0, accessDrive = 2'h0;
  logic [1:0] accessDataPort = 2'h0, accessWord32 = 2'h3;
  logic [31:0] cfgReadData, ultraCycleNs;
  logic cfgReadValid;
  logic [1:0] accessBusy, accessDone, accessRefused, channelOn, postedWriteOn, prefetchOn;
  logic [1:0] drive_read_strobe_n, drive_write_strobe_n;
  logic [3:0] ultraEnabled, cable80;
  logic [27:0] busMasterIoBase;
  logic [4:0] lowLen0, lowLen1;
  int fails = 0, n_tests = 0;
  logic [7:0] ofs [8] = '{8'h20, 8'h2c, 8'h3c, 8'h40, 8'h48, 8'h4c, 8'h50, 8'h60};
  logic [31:0] rv [8] = '{32'h0000cc01, 32'h0, 32'h0, 32'h00000400, 32'ha8a8a8a8,
    32'hffff00ff, 32'h03030303, 32'h0};
  logic [31:0] ones [8] = '{32'hfffffff1, 32'h0, 32'h0, 32'h00fff403, 32'hffffffff,
    32'hffff00ff, 32'hc7c7c7c7, 32'h0};
  ictr_config_regs u_ictr_config_regs (.*);
  ictr_drive_model u_ictr_drive_model (.clk(clk), .reset(reset),
    .readStrobe_n(drive_read_strobe_n), .writeStrobe_n(drive_write_strobe_n),
    .lowLen0(lowLen0), .lowLen1(lowLen1));
  always #25 clk = ~clk;
  // ----
  // Shared bus and check tasks
  // ----
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk);
    cfgWrite = 1'b1; cfgAddr = a; cfgWriteData = d; cfgByteEn = be;
    @(negedge clk);
    cfgWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    cfgRead = 1'b1; cfgAddr = a;
    @(negedge clk);
    cfgRead = 1'b0;
    chk("readValid", 32'h1, {31'h0, cfgReadValid});
    chk("readData", e, cfgReadData);
  endtask : rd
  // Waits on done with a cap so a stuck timer shows as a mismatch, not a hang
  task automatic acc(input int ch, input logic dv, input logic w, input logic dp,
                     input logic [4:0] exp);
    int k;
    @(negedge clk);
    accessStart[ch] = 1'b1; accessDrive[ch] = dv; accessWrite[ch] = w; accessDataPort[ch] = dp;
    @(negedge clk);
    accessStart[ch] = 1'b0;
    k = 0;
    while (accessDone[ch] !== 1'b1 && k < 80) begin
      @(negedge clk);
      k++;
    end
    chk("accessDone", 32'h1, {31'h0, accessDone[ch]});
    @(negedge clk);
    chk("strobeLow", {27'h0, exp}, {27'h0, (ch == 1) ? lowLen1 : lowLen0});
  endtask : acc
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd(ofs[i], rv[i]);
    chk("bmBase", 32'h00000cc0, {4'h0, busMasterIoBase});
  endtask : t_reset
  task automatic t_masks;
    for (int i = 0; i < 8; i++) begin
      wr(ofs[i], (i == 3) ? 32'hfffff4e3 : 32'hffffffff, 4'hf);
      rd(ofs[i], ones[i]);
      wr(ofs[i], rv[i], 4'hf);
    end
    wr(8'h48, 32'h0, 4'h2);
    rd(8'h48, 32'ha8a800a8);
    wr(8'h48, 32'ha8a8a8a8, 4'hf);
  endtask : t_masks
  task automatic t_intr;
    @(negedge clk);
    subsysAliasWrite = 1'b1; subsysAliasData = 32'h5a5a1234;
    @(negedge clk);
    subsysAliasWrite = 1'b0;
    rd(8'h2c, 32'h5a5a1234);
    wr(8'h3c, 32'hffffff5a, 4'hf);
    rd(8'h3c, 32'h0);
    priNative = 1'b1;
    rd(8'h3c, 32'h00000100);
    wr(8'h3c, 32'h00000033, 4'hf);
    priNative = 1'b0; secNative = 1'b1;
    rd(8'h3c, 32'h00000133);
    secNative = 1'b0;
    rd(8'h3c, 32'h0);
  endtask : t_intr
  task automatic t_pio;
    logic [7:0] m [5] = '{8'ha8, 8'h65, 8'h42, 8'h22, 8'h20};
    wr(8'h40, 32'h00000403, 4'hf);
    foreach (m[i]) begin
      wr(8'h48, {m[i], 24'ha8a8a8}, 4'hf);
      acc(0, 1'b0, 1'b0, 1'b1, {1'b0, m[i][7:4]} + 5'h1);
    end
    // A write during the setup phase must not reach the running access
    fork
      acc(0, 1'b0, 1'b0, 1'b1, 5'h3);
      begin
        repeat (2) @(negedge clk);
        wr(8'h48, 32'ha8a8a8a8, 4'hf);
      end
    join
    wr(8'h48, 32'ha8a8a831, 4'hf);
    acc(1, 1'b1, 1'b0, 1'b1, 5'h4);
    wr(8'h4c, 32'h2fff00ff, 4'hf);
    acc(0, 1'b0, 1'b0, 1'b0, 5'h3);
    wr(8'h4c, 32'hffff00ff, 4'hf);
  endtask : t_pio
  task automatic t_rules;
    wr(8'h40, 32'h0005c403, 4'hf);
    chk("flags", 32'h00000157, {22'h0, cable80, prefetchOn, postedWriteOn, channelOn});
    @(negedge clk);
    accessStart[0] = 1'b1; accessWrite[0] = 1'b1; accessDataPort[0] = 1'b1; accessWord32[0] = 1'b0;
    #1 chk("refused", 32'h1, {31'h0, accessRefused[0]});
    @(negedge clk);
    accessStart[0] = 1'b0; accessWord32[0] = 1'b1;
    @(negedge clk);
    chk("busyRefused", 32'h0, {31'h0, accessBusy[0]});
    acc(0, 1'b0, 1'b1, 1'b1, 5'hb);
    wr(8'h40, 32'h00000401, 4'hf);
    @(negedge clk);
    accessStart[0] = 1'b1; accessWrite[0] = 1'b0;
    @(negedge clk);
    accessStart[0] = 1'b0;
    @(negedge clk);
    chk("busyOff", 32'h0, {31'h0, accessBusy[0]});
    wr(8'h40, 32'h00000400, 4'hf);
  endtask : t_rules
  task automatic t_udma;
    wr(8'h50, 32'hc0c1c2c3, 4'hf);
    @(negedge clk);
    chk("ultraOn", 32'hf, {28'h0, ultraEnabled});
    chk("ultraNs", 32'h96785a3c, ultraCycleNs);
    wr(8'h50, 32'hc4c5c647, 4'hf);
    rd(8'h50, 32'hc4c5c647);
    chk("ultraOn", 32'h7, {28'h0, ultraEnabled});
    chk("ultraNs", 32'h00141e2d, ultraCycleNs);
    @(negedge clk);
    setFeaturesSeen = 4'h8;
    @(negedge clk);
    setFeaturesSeen = 4'h0;
    repeat (2) @(negedge clk);
    chk("ultraAuto", 32'hf, {28'h0, ultraEnabled});
  endtask : t_udma
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_masks();
    t_intr();
    t_pio();
    t_rules();
    t_udma();
    test_done();
  end
  // Whole run is a few hundred cycles; this bound is far past it
  initial begin
    #(50 * 30000);
    fails++;
    test_done();
  end
endmodule : tb_ictr_config_regs
`default_nettype wire
